/* File: logic/ahs_pkg.sv */
package ahs_pkg;
    typedef enum logic [2:0] {
        RAMP_CONST, RAMP_TRAP1, RAMP_TRAP2, RAMP_TRAP3, RAMP_SCURVE1,
        RAMP_SCURVE2
    } ahs_ramp_t;
    typedef struct packed {
        logic [2:0]  ramp;
        logic [18:0] startSpd;
        logic [18:0] driveSpd;
        logic [13:0] accMs;
        logic [13:0] decMs;
        logic [18:0] lowSpd;
    } ahs_prof_t;
    typedef struct packed {
        logic        dir;
        logic        hiSpeed;
        logic        counted;
        logic [31:0] count;
    } ahs_move_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_S1GO, ST_S1RUN, ST_S2CHK, ST_S2RUN, ST_RVHI, ST_RVLO,
        ST_S3CHK, ST_S3RUN, ST_S4GO, ST_S4WAIT, ST_S4RUN, ST_HALT, ST_DONE
    } ahs_state_t;
endpackage : ahs_pkg

/* File: logic/ahs_regs.svh */
// Operation
// - Steps run in order one to four; disabled steps are skipped.
// - Step one moves at high profile until detection, then decelerates.
// - With clear enabled, position counter is zeroed at sequence end without homing or limit error.
// - Step two moves at low speed until detection, then stops instantly.
// - Detection active at step two start: back off slowly, then retry.
// - Search limit active at step two start: fast reverse, slow, retry.
// - Search limit hit during step two: stop, then limit recovery.
// - Same direction and input inactive at step two: fast/slow reverse.
// - Step three moves at low speed until index, then stops instantly.
// - Index already active at step three start: homing error, end.
// - Search limit active at step three start: limit error, end.
// - Search limit hit during step three: limit error, end.
// - Step four moves the signed offset at high profile.
// - Software position limits are ignored while homing runs.
// - High-speed moves use the fourth speed set profile settings.
// - Limit source uses the limit in each step's search direction.
// - Home and index active levels selectable, low by default.
// - Four step enables off by default; directions -,-,+ by default.
// - Ramp choice has six options, default ramp with start speed.
`ifndef AHS_REGS_SVH
`define AHS_REGS_SVH
`define AHS_CTRL       8'h00
`define AHS_CFG        8'h04
`define AHS_START      8'h08
`define AHS_DRIVE      8'h0C
`define AHS_ACC        8'h10
`define AHS_DEC        8'h14
`define AHS_LOW        8'h18
`define AHS_OFFSET     8'h1C
`define AHS_STATUS     8'h20
`define AHS_B_SRCLIM   0
`define AHS_B_HOMEHI   1
`define AHS_B_IDXHI    2
`define AHS_B_LIMHI    3
`define AHS_B_LIMSLOW  4
`define AHS_B_POSCLR   5
`define AHS_B_EN       8
`define AHS_B_DIR      12
`define AHS_B_RAMP     16
`define AHS_CFG_RST    32'h0002_4020
`define AHS_SPD_MAX    32'h0007_A120
`define AHS_MS_MAX     32'h0000_2710
`define AHS_START_RST  32'h0000_0FA0
`define AHS_DRIVE_RST  32'h0000_9C40
`define AHS_ACC_RST    32'h0000_01F4
`define AHS_LOW_RST    32'h0000_0FA0
`define AHS_OFF_RST    32'h0000_0064
`define AHS_OFF_MAX    32'h7FFF_FFFE
`endif

/* File: logic/ahs_sequencer.sv */
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "ahs_regs.svh"
module ahs_sequencer (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              homePin,
    input  wire logic              indexPin,
    input  wire logic              limPosPin,
    input  wire logic              limNegPin,
    input  wire logic              pgBusy,
    output ahs_pkg::ahs_move_t     moveCmd,
    output logic                   moveGo,
    output logic                   stopNow,
    output logic                   stopDecel,
    output ahs_pkg::ahs_prof_t     profile,
    output logic                   limStopSlow,
    output logic                   limActiveHigh,
    output logic                   swLimIgnore,
    output logic                   posClear
);
    logic [31:0] cfg_r, cfg_nxt, start_r, start_nxt, drive_r, drive_nxt;
    logic [31:0] acc_r, acc_nxt, dec_r, dec_nxt, low_r, low_nxt;
    logic [31:0] off_r, off_nxt;
    logic [3:0]  sync1_r, sync2_r;
    ahs_pkg::ahs_state_t st_r, st_nxt, ret_r, ret_nxt;
    ahs_pkg::ahs_move_t  mv_r, mv_nxt;
    logic go_r, go_nxt, sn_r, sn_nxt, sd_r, sd_nxt, pc_r, pc_nxt;
    logic done_r, done_nxt, herr_r, herr_nxt, lerr_r, lerr_nxt;
    logic rec_r, rec_nxt;
    logic wr, startReq, abortReq;
    logic homeAct, idxAct, limP, limN, srcLim;
    logic [3:0] en;
    logic [2:0] dir;
    logic [31:0] offAbs;

    // Clamp a written value into 1..max
    function automatic logic [31:0] clampVal(input logic [31:0] v,
                                             input logic [31:0] mx);
        clampVal = (v == 32'h0000_0000) ? 32'h0000_0001 :
                   ((v > mx) ? mx : v);
    endfunction : clampVal

    // Clamp the signed offset into its legal symmetric range
    function automatic logic [31:0] clampOff(input logic [31:0] v);
        logic signed [31:0] s;
        s = v;
        if (s > $signed(`AHS_OFF_MAX))
            clampOff = `AHS_OFF_MAX;
        else if (s < -$signed(`AHS_OFF_MAX))
            clampOff = -`AHS_OFF_MAX;
        else
            clampOff = v;
    endfunction : clampOff

    assign wr       = psel && penable && pwrite;
    assign startReq = wr && paddr == `AHS_CTRL && pwdata[0];
    assign abortReq = wr && paddr == `AHS_CTRL && pwdata[1];
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !(paddr inside {`AHS_CTRL,
                      `AHS_CFG, `AHS_START, `AHS_DRIVE, `AHS_ACC, `AHS_DEC,
                      `AHS_LOW, `AHS_OFFSET, `AHS_STATUS});

    // Speed and time writes are clamped so the generator never sees zero
    always_comb begin
        cfg_nxt   = cfg_r;
        start_nxt = start_r;
        drive_nxt = drive_r;
        acc_nxt   = acc_r;
        dec_nxt   = dec_r;
        low_nxt   = low_r;
        off_nxt   = off_r;
        if (wr) begin
            unique case (paddr)
                `AHS_CFG:    cfg_nxt   = pwdata & 32'h0007_7F3F;
                `AHS_START:  start_nxt = clampVal(pwdata, `AHS_SPD_MAX);
                `AHS_DRIVE:  drive_nxt = clampVal(pwdata, `AHS_SPD_MAX);
                `AHS_ACC:    acc_nxt   = clampVal(pwdata, `AHS_MS_MAX);
                `AHS_DEC:    dec_nxt   = clampVal(pwdata, `AHS_MS_MAX);
                `AHS_LOW:    low_nxt   = clampVal(pwdata, `AHS_SPD_MAX);
                `AHS_OFFSET: off_nxt   = clampOff(pwdata);
                default: ;
            endcase
            if (paddr == `AHS_CFG && pwdata[18:16] > 3'h5)
                cfg_nxt[18:16] = cfg_r[18:16];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r   <= `AHS_CFG_RST;
            start_r <= `AHS_START_RST;
            drive_r <= `AHS_DRIVE_RST;
            acc_r   <= `AHS_ACC_RST;
            dec_r   <= `AHS_ACC_RST;
            low_r   <= `AHS_LOW_RST;
            off_r   <= `AHS_OFF_RST;
        end else begin
            cfg_r   <= cfg_nxt;
            start_r <= start_nxt;
            drive_r <= drive_nxt;
            acc_r   <= acc_nxt;
            dec_r   <= dec_nxt;
            low_r   <= low_nxt;
            off_r   <= off_nxt;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            `AHS_CFG:    prdata = cfg_r;
            `AHS_START:  prdata = start_r;
            `AHS_DRIVE:  prdata = drive_r;
            `AHS_ACC:    prdata = acc_r;
            `AHS_DEC:    prdata = dec_r;
            `AHS_LOW:    prdata = low_r;
            `AHS_OFFSET: prdata = off_r;
            `AHS_STATUS: prdata = {28'h0000000, lerr_r, herr_r, done_r,
                                   st_r != ahs_pkg::ST_IDLE};
            default: ;
        endcase
    end

    // Pins are asynchronous to clk
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= {limNegPin, limPosPin, indexPin, homePin};
            sync2_r <= sync1_r;
        end
    end

    assign srcLim  = cfg_r[`AHS_B_SRCLIM];
    assign en      = cfg_r[`AHS_B_EN +: 4];
    assign dir     = cfg_r[`AHS_B_DIR +: 3];
    assign homeAct = sync2_r[0] ~^ cfg_r[`AHS_B_HOMEHI];
    assign idxAct  = sync2_r[1] ~^ cfg_r[`AHS_B_IDXHI];
    assign limP    = sync2_r[2] ~^ cfg_r[`AHS_B_LIMHI];
    assign limN    = sync2_r[3] ~^ cfg_r[`AHS_B_LIMHI];
    assign offAbs  = off_r[31] ? -off_r : off_r;

    function automatic logic limIn(input logic d, input logic p,
                                   input logic n);
        limIn = d ? p : n;
    endfunction : limIn

    logic lim1, lim2, lim3, det1, det2;
    assign lim1 = limIn(dir[0], limP, limN);
    assign lim2 = limIn(dir[1], limP, limN);
    assign lim3 = limIn(dir[2], limP, limN);
    assign det1 = srcLim ? lim1 : homeAct;
    assign det2 = srcLim ? lim2 : homeAct;

    // Motion is launched with a one-cycle go and watched through pgBusy
    always_comb begin
        st_nxt   = st_r;
        ret_nxt  = ret_r;
        mv_nxt   = mv_r;
        go_nxt   = 1'b0;
        sn_nxt   = 1'b0;
        sd_nxt   = 1'b0;
        pc_nxt   = 1'b0;
        done_nxt = done_r;
        herr_nxt = herr_r;
        lerr_nxt = lerr_r;
        rec_nxt  = rec_r;
        unique case (st_r)
            ahs_pkg::ST_IDLE: begin
                if (startReq) begin
                    st_nxt   = ahs_pkg::ST_S1GO;
                    done_nxt = 1'b0;
                    herr_nxt = 1'b0;
                    lerr_nxt = 1'b0;
                    rec_nxt  = 1'b0;
                end
            end
            ahs_pkg::ST_S1GO: begin
                if (!en[0] || det1 || (!srcLim && lim1))
                    st_nxt = ahs_pkg::ST_S2CHK;
                else begin
                    mv_nxt = '{dir[0], 1'b1, 1'b0, 32'h0};
                    go_nxt = 1'b1;
                    st_nxt = ahs_pkg::ST_S1RUN;
                end
            end
            ahs_pkg::ST_S1RUN: begin
                if (det1 || (!srcLim && lim1)) begin
                    sd_nxt  = 1'b1;
                    ret_nxt = ahs_pkg::ST_S2CHK;
                    st_nxt  = ahs_pkg::ST_HALT;
                end
            end
            ahs_pkg::ST_S2CHK: begin
                if (!en[1])
                    st_nxt = ahs_pkg::ST_S3CHK;
                else if (det2) begin
                    mv_nxt  = '{!dir[1], 1'b0, 1'b0, 32'h0};
                    go_nxt  = 1'b1;
                    rec_nxt = 1'b1;
                    st_nxt  = ahs_pkg::ST_RVLO;
                end else if ((!srcLim && lim2) ||
                             (!rec_r && en[0] && dir[0] == dir[1])) begin
                    mv_nxt  = '{!dir[1], 1'b1, 1'b0, 32'h0};
                    go_nxt  = 1'b1;
                    rec_nxt = 1'b1;
                    st_nxt  = ahs_pkg::ST_RVHI;
                end else begin
                    mv_nxt = '{dir[1], 1'b0, 1'b0, 32'h0};
                    go_nxt = 1'b1;
                    st_nxt = ahs_pkg::ST_S2RUN;
                end
            end
            ahs_pkg::ST_S2RUN: begin
                if (det2) begin
                    sn_nxt  = 1'b1;
                    ret_nxt = ahs_pkg::ST_S3CHK;
                    st_nxt  = ahs_pkg::ST_HALT;
                end else if (!srcLim && lim2) begin
                    sn_nxt  = 1'b1;
                    ret_nxt = ahs_pkg::ST_S2CHK;
                    st_nxt  = ahs_pkg::ST_HALT;
                end
            end
            ahs_pkg::ST_RVHI: begin
                if (det2) begin
                    sd_nxt  = 1'b1;
                    ret_nxt = ahs_pkg::ST_RVLO;
                    st_nxt  = ahs_pkg::ST_HALT;
                end
            end
            ahs_pkg::ST_RVLO: begin
                if (!go_r && !pgBusy) begin
                    mv_nxt = '{!dir[1], 1'b0, 1'b0, 32'h0};
                    go_nxt = 1'b1;
                end else if (!det2) begin
                    sn_nxt  = 1'b1;
                    ret_nxt = ahs_pkg::ST_S2CHK;
                    st_nxt  = ahs_pkg::ST_HALT;
                end
            end
            ahs_pkg::ST_S3CHK: begin
                if (!en[2])
                    st_nxt = ahs_pkg::ST_S4GO;
                else if (idxAct) begin
                    herr_nxt = 1'b1;
                    st_nxt   = ahs_pkg::ST_DONE;
                end else if (lim3) begin
                    lerr_nxt = 1'b1;
                    st_nxt   = ahs_pkg::ST_DONE;
                end else begin
                    mv_nxt = '{dir[2], 1'b0, 1'b0, 32'h0};
                    go_nxt = 1'b1;
                    st_nxt = ahs_pkg::ST_S3RUN;
                end
            end
            ahs_pkg::ST_S3RUN: begin
                if (lim3) begin
                    sn_nxt   = 1'b1;
                    lerr_nxt = 1'b1;
                    ret_nxt  = ahs_pkg::ST_DONE;
                    st_nxt   = ahs_pkg::ST_HALT;
                end else if (idxAct) begin
                    sn_nxt  = 1'b1;
                    ret_nxt = ahs_pkg::ST_S4GO;
                    st_nxt  = ahs_pkg::ST_HALT;
                end
            end
            ahs_pkg::ST_S4GO: begin
                if (!en[3] || off_r == 32'h0)
                    st_nxt = ahs_pkg::ST_DONE;
                else begin
                    mv_nxt = '{!off_r[31], 1'b1, 1'b1, offAbs};
                    go_nxt = 1'b1;
                    st_nxt = ahs_pkg::ST_S4WAIT;
                end
            end
            ahs_pkg::ST_S4WAIT: begin
                if (pgBusy)
                    st_nxt = ahs_pkg::ST_S4RUN;
            end
            ahs_pkg::ST_S4RUN: begin
                if (!pgBusy)
                    st_nxt = ahs_pkg::ST_DONE;
            end
            // Wait out the stop; a decelerating stop takes many cycles
            ahs_pkg::ST_HALT: begin
                if (!pgBusy && !sn_r && !sd_r)
                    st_nxt = ret_r;
            end
            ahs_pkg::ST_DONE: begin
                pc_nxt   = cfg_r[`AHS_B_POSCLR] && !herr_r && !lerr_r;
                done_nxt = 1'b1;
                st_nxt   = ahs_pkg::ST_IDLE;
            end
        endcase
        if (abortReq && st_r != ahs_pkg::ST_IDLE &&
            st_r != ahs_pkg::ST_DONE) begin
            sn_nxt  = 1'b1;
            go_nxt  = 1'b0;
            ret_nxt = ahs_pkg::ST_DONE;
            st_nxt  = ahs_pkg::ST_HALT;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r   <= ahs_pkg::ST_IDLE;
            ret_r  <= ahs_pkg::ST_IDLE;
            mv_r   <= '0;
            go_r   <= 1'b0;
            sn_r   <= 1'b0;
            sd_r   <= 1'b0;
            pc_r   <= 1'b0;
            done_r <= 1'b0;
            herr_r <= 1'b0;
            lerr_r <= 1'b0;
            rec_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            ret_r  <= ret_nxt;
            mv_r   <= mv_nxt;
            go_r   <= go_nxt;
            sn_r   <= sn_nxt;
            sd_r   <= sd_nxt;
            pc_r   <= pc_nxt;
            done_r <= done_nxt;
            herr_r <= herr_nxt;
            lerr_r <= lerr_nxt;
            rec_r  <= rec_nxt;
        end
    end

    assign moveCmd          = mv_r;
    assign moveGo           = go_r;
    assign stopNow          = sn_r;
    assign stopDecel        = sd_r;
    assign posClear         = pc_r;
    assign swLimIgnore      = st_r != ahs_pkg::ST_IDLE;
    assign limStopSlow      = cfg_r[`AHS_B_LIMSLOW];
    assign limActiveHigh    = cfg_r[`AHS_B_LIMHI];
    assign profile.ramp     = cfg_r[`AHS_B_RAMP +: 3];
    assign profile.startSpd = start_r[18:0];
    assign profile.driveSpd = drive_r[18:0];
    assign profile.accMs    = acc_r[13:0];
    assign profile.decMs    = dec_r[13:0];
    assign profile.lowSpd   = low_r[18:0];
endmodule : ahs_sequencer

/* File: verification/ahs_motor_model.sv */
`timescale 1ns/1ns
module ahs_motor_model (
    input wire logic               clk,
    input wire logic               rstn,
    input wire ahs_pkg::ahs_move_t moveCmd,
    input wire logic               moveGo,
    input wire logic               stopNow,
    input wire logic               stopDecel,
    input wire logic               posClear,
    input wire logic               setEn,
    input wire logic signed [31:0] setVal,
    input wire logic signed [31:0] homeLo,
    input wire logic signed [31:0] homeHi,
    input wire logic signed [31:0] idxLo,
    input wire logic signed [31:0] limPosAt,
    output logic                   pgBusy,
    output logic                   homePin,
    output logic                   indexPin,
    output logic                   limPosPin,
    output logic                   limNegPin,
    output logic signed [31:0]     pos
);
    logic               dirR;
    logic signed [31:0] left;
    // Active low, shorted to common inside the window
    assign homePin   = !(pos >= homeLo && pos <= homeHi);
    assign indexPin  = !(pos >= idxLo && pos <= idxLo + 10);
    assign limPosPin = !(pos >= limPosAt);
    assign limNegPin = 1'b1;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pgBusy <= 1'b0;
            pos    <= 0;
            left   <= 0;
            dirR   <= 1'b0;
        end else if (setEn) begin
            pos <= setVal;
        end else if (posClear) begin
            pos <= 0;
        end else if (moveGo) begin
            pgBusy <= 1'b1;
            dirR   <= moveCmd.dir;
            left   <= moveCmd.counted ? $signed(moveCmd.count) : -1;
        end else if (stopNow) begin
            pgBusy <= 1'b0;
        end else if (stopDecel) begin
            left <= 3;
        end else if (pgBusy) begin
            pos <= dirR ? pos + 1 : pos - 1;
            if (left == 1)
                pgBusy <= 1'b0;
            if (left > 0)
                left <= left - 1;
        end
    end
endmodule : ahs_motor_model

/* File: verification/ahs_sequencer_sva.sv */
`timescale 1ns/1ns
module ahs_sequencer_sva (
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic               pslverr,
    input wire logic               pgBusy,
    input wire ahs_pkg::ahs_move_t moveCmd,
    input wire logic               moveGo,
    input wire logic               stopNow,
    input wire logic               stopDecel,
    input wire ahs_pkg::ahs_prof_t profile,
    input wire logic               swLimIgnore,
    input wire logic               posClear
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_go_pulse: assert property (moveGo |=> !moveGo)
        else $error("move start wider than one cycle");
    chk_go_when_idle: assert property (moveGo |-> !pgBusy)
        else $error("move started while generator busy");
    chk_swlim_hold: assert property (moveGo |-> swLimIgnore)
        else $error("soft limits honoured during homing");
    chk_stop_kinds: assert property (
        stopNow |-> !stopDecel && swLimIgnore)
        else $error("instant stop mixed with slow stop");
    chk_offset_fast: assert property (
        moveGo && moveCmd.counted |-> moveCmd.hiSpeed)
        else $error("offset move not at high speed");
    chk_clear_quiet: assert property (posClear |-> !pgBusy && !moveGo)
        else $error("position clear during motion");
    chk_ramp_legal: assert property (profile.ramp <= 3'h5)
        else $error("ramp code out of range");
    chk_speed_range: assert property (
        profile.startSpd inside {[19'h1:19'h7A120]} &&
        profile.driveSpd inside {[19'h1:19'h7A120]} &&
        profile.lowSpd inside {[19'h1:19'h7A120]})
        else $error("speed out of range");
    chk_time_range: assert property (
        profile.accMs inside {[14'h1:14'h2710]} &&
        profile.decMs inside {[14'h1:14'h2710]})
        else $error("ramp time out of range");
    chk_prof_stable: assert property (
        !(psel && penable && pwrite) |=> $stable(profile))
        else $error("profile changed without a write");
    chk_unmapped_err: assert property (
        psel && penable && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
endmodule : ahs_sequencer_sva
bind ahs_sequencer ahs_sequencer_sva ahs_sequencer_sva_inst (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .pgBusy(pgBusy),
    .moveCmd(moveCmd), .moveGo(moveGo), .stopNow(stopNow),
    .stopDecel(stopDecel), .profile(profile),
    .swLimIgnore(swLimIgnore), .posClear(posClear));

/* File: verification/ahs_sequencer_tb.sv */
`timescale 1ns/1ns
module ahs_sequencer_tb;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, er, setEn;
    logic homePin, indexPin, limPosPin, limNegPin, pgBusy, moveGo;
    logic stopNow, stopDecel, limStopSlow, limActiveHigh, swLimIgnore;
    logic posClear;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic signed [31:0] setVal, homeLo, homeHi, idxLo, limPosAt, pos;
    ahs_pkg::ahs_move_t moveCmd;
    ahs_pkg::ahs_prof_t profile;
    int fails, testsRun;
    ahs_sequencer ahs_sequencer_inst (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .homePin(homePin), .indexPin(indexPin), .limPosPin(limPosPin),
        .limNegPin(limNegPin), .pgBusy(pgBusy), .moveCmd(moveCmd),
        .moveGo(moveGo), .stopNow(stopNow), .stopDecel(stopDecel),
        .profile(profile), .limStopSlow(limStopSlow),
        .limActiveHigh(limActiveHigh), .swLimIgnore(swLimIgnore),
        .posClear(posClear));
    ahs_motor_model ahs_motor_model_inst (.clk(clk), .rstn(rstn),
        .moveCmd(moveCmd), .moveGo(moveGo), .stopNow(stopNow),
        .stopDecel(stopDecel), .posClear(posClear), .setEn(setEn),
        .setVal(setVal), .homeLo(homeLo), .homeHi(homeHi), .idxLo(idxLo),
        .limPosAt(limPosAt), .pgBusy(pgBusy), .homePin(homePin),
        .indexPin(indexPin), .limPosPin(limPosPin), .limNegPin(limNegPin),
        .pos(pos));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
            fails++;
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Places the axis, starts homing, polls status until done
    task automatic run(input logic [31:0] cfg, input logic signed [31:0] p0);
        int n;
        apb(1'b1, 8'h04, cfg);
        @(posedge clk);
        setVal <= p0;
        setEn <= 1'b1;
        @(posedge clk);
        setEn <= 1'b0;
        apb(1'b1, 8'h00, 32'h0000_0001);
        n = 0;
        do begin
            apb(1'b0, 8'h20, 32'h0);
            n++;
        end while (!(rd[1] === 1'b1 && rd[0] === 1'b0) && n < 3000);
        if (n >= 3000) begin
            fails++;
            end_of_test();
        end
        // Lets the model apply a clear pulse issued with done
        @(posedge clk);
    endtask : run
    logic [7:0]  ra[8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
        8'h20};
    logic [31:0] rv[8] = '{32'h0002_4020, 32'h0000_0FA0, 32'h0000_9C40,
        32'h0000_01F4, 32'h0000_01F4, 32'h0000_0FA0, 32'h0000_0064, 32'h0};
    logic [31:0] cw[4] = '{32'h0009_27C0, 32'h0000_4E20, 32'h0, 32'h0};
    logic [31:0] ce[4] = '{32'h0007_A120, 32'h0000_2710, 32'h1, 32'h1};
    // Index search cases: start, index window, plus limit, status
    int s3p[4] = '{500, 605, 800, 500};
    int s3i[4] = '{600, 600, 5000, 5000};
    int s3l[4] = '{5000, 5000, 700, 700};
    logic [31:0] s3s[4] = '{32'h2, 32'h6, 32'hA, 32'hA};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rstn, psel, penable, pwrite, setEn} = '0;
        paddr = 8'h0;
        pwdata = 32'h0;
        setVal = 0;
        homeLo = 100;
        homeHi = 200;
        idxLo = 100000;
        limPosAt = 100000;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, rv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h0C + 8'(4 * i), cw[i]);
            apb(1'b0, 8'h0C + 8'(4 * i), 32'h0);
            check(rd, ce[i]);
        end
        apb(1'b1, 8'h04, 32'h0007_0000);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0002_0000);
        apb(1'b0, 8'h24, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, 8'h1C, 32'h0000_0032);
        // Trap2 ramp, steps 1, 2 negative, step 4 offset +50; slow stop lands inside home
        run(32'h0002_0B00, 1000);
        check(rd, 32'h2);
        check({31'h0, pos >= 230 && pos <= 262}, 32'h1);
        run(32'h0002_0B20, 1000);
        check(pos, 32'h0);
        // Narrow home: slow stop overshoots it, so step two turns back
        homeLo <= 197;
        run(32'h0002_0B00, 1000);
        check(rd, 32'h2);
        check({31'h0, pos >= 230 && pos <= 262}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            idxLo <= s3i[i];
            limPosAt <= s3l[i];
            run(32'h0002_4400, s3p[i]);
            check(rd, s3s[i]);
            if (i == 0)
                check({31'h0, pos >= 600 && pos <= 615}, 32'h1);
        end
        // Positive limit as the sensor for steps one and two
        limPosAt <= 2000;
        run(32'h0002_3311, 1000);
        check(rd, 32'h2);
        check({31'h0, pos >= 2000 && pos <= 2010}, 32'h1);
        check({30'h0, limActiveHigh, limStopSlow}, 32'h1);
        // Abort lands one cycle after the reverse move is launched
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_0002);
        repeat (8) @(posedge clk);
        apb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h2);
        end_of_test();
    end
endmodule : ahs_sequencer_tb
